// file: logic/opdec_defines.svh
// Purpose: constants for the logic and transfer opcode decoder
// Assumes: opcodes are eight bits, low nibble 8..F names a working register
// Notes:   timing figures are oscillator periods per one or per two machine cycles
`ifndef OPDEC_DEFINES_SVH
`define OPDEC_DEFINES_SVH

// ************************************************************
// opcode encodings (full bytes)
// ************************************************************
`define OP_AND_A_DIR    8'h55
`define OP_AND_A_IMM    8'h54
`define OP_AND_DIR_A    8'h52
`define OP_AND_DIR_IMM  8'h53
`define OP_OR_A_DIR     8'h45
`define OP_OR_A_IMM     8'h44
`define OP_OR_DIR_A     8'h42
`define OP_OR_DIR_IMM   8'h43
`define OP_XOR_A_DIR    8'h65
`define OP_XOR_A_IMM    8'h64
`define OP_XOR_DIR_A    8'h62
`define OP_XOR_DIR_IMM  8'h63
`define OP_CLR_A        8'hE4
`define OP_CPL_A        8'hF4
`define OP_SWAP_A       8'hC4
`define OP_RL_A         8'h23
`define OP_RLC_A        8'h33
`define OP_RR_A         8'h03
`define OP_RRC_A        8'h13
`define OP_LD_A_DIR     8'hE5
`define OP_LD_A_IMM     8'h74
`define OP_ST_DIR_A     8'hF5
`define OP_CP_DIR_DIR   8'h85
`define OP_ST_DIR_IMM   8'h75
`define OP_LD_DATA_POINTER      8'h90
`define OP_CODE_DATA_POINTER    8'h93
`define OP_CODE_PC      8'h83
`define OP_XRD_DATA_POINTER     8'hE0
`define OP_XWR_DATA_POINTER     8'hF0
`define OP_PUSH         8'hC0
`define OP_POP          8'hD0
`define OP_XCH_DIR      8'hC5
// direct address at which the accumulator itself answers
`define ACC_DIR_ADDR    8'hE0

// ************************************************************
// opcode families by upper nibble
// ************************************************************
`define HI_AND   4'h5
`define HI_OR    4'h4
`define HI_XOR   4'h6
`define HI_LDA   4'hE
`define HI_STR   4'hF
`define HI_LDRD  4'hA
`define HI_LDRI  4'h7
`define HI_STD   4'h8
`define HI_XCH   4'hC
`define HI_LOW_DIGIT_EXCHANGE_OP  4'hD
`define HI_XRD   4'hE
`define HI_XWR   4'hF
// indirect pair low nibbles (bit 0 picks register 0 or 1)
`define LO_IND   3'h3
`define LO_XIND  3'h1

// ************************************************************
// timing and instruction length
// ************************************************************
`define OSC_PER_MCYCLE  12
`define TWO_MC_PERIODS  24
`define MAX_BYTES       2'h3

`endif

// file: logic/opdec_pkg.sv
// Purpose: types shared by the opcode decoder files
// Assumes: nothing beyond the defines header
// Notes:   holds types only
`default_nettype none
package opdec_pkg;

  // ************************************************************
  // operation classes
  // ************************************************************
  typedef enum logic [4:0] {
    OPC_ILLEGAL, OPC_AND, OPC_OR, OPC_XOR, OPC_CLR, OPC_CPL,
    OPC_SWAP, OPC_RL, OPC_RLC, OPC_RR, OPC_RRC, OPC_MOVE,
    OPC_LD_DATA_POINTER, OPC_CODE_DATA_POINTER, OPC_CODE_PC, OPC_XRD, OPC_XWR,
    OPC_PUSH, OPC_POP, OPC_XCH, OPC_LOW_DIGIT_EXCHANGE_OP
  } op_class_t;

  // operand sources and destinations
  typedef enum logic [2:0] {
    LOC_NONE, LOC_ACC, LOC_REG, LOC_DIR, LOC_IND, LOC_IMM, LOC_DATA_POINTER
  } loc_t;

  // one decoded instruction
  typedef struct packed {
    logic       legal;
    op_class_t  op;
    loc_t       dst;
    loc_t       src;
    logic [2:0] reg_sel;
    logic [1:0] bytes;
    logic [1:0] cycles;
  } dec_t;

  // assembled instruction leaving the sequencer
  typedef struct packed {
    dec_t        dec;
    logic [7:0]  operand1;
    logic [7:0]  operand2;
  } instr_t;

endpackage
`default_nettype wire

// file: logic/opdec_table.sv
// Purpose: combinational opcode table for logic and transfer opcodes
// Assumes: opcode byte stable while read
// Notes:   opcodes outside this group decode as not legal
`timescale 1ns/10ps
`default_nettype none
`include "opdec_defines.svh"

module opdec_table
  import opdec_pkg::*;
(
  input  wire logic [7:0] opcode_i,
  output dec_t            dec_o
);

  logic [3:0] hi;
  logic [3:0] lo;
  logic       is_reg;
  logic       is_ind;
  assign hi     = opcode_i[7:4];
  assign lo     = opcode_i[3:0];
  assign is_reg = lo[3];
  assign is_ind = (lo[3:1] == `LO_IND);

  // ************************************************************
  // decode
  // ************************************************************
  // each case fills one entry; defaults give an illegal one-byte slot
  always_comb
  begin
    dec_o         = '0;
    dec_o.op      = OPC_ILLEGAL;
    dec_o.dst     = LOC_NONE;
    dec_o.src     = LOC_NONE;
    dec_o.bytes   = 2'h1;
    dec_o.cycles  = 2'h1;
    // register number, or R0/R1 for indirect pairs
    dec_o.reg_sel = is_reg ? lo[2:0] : {2'h0, lo[0]};
    if (is_reg || is_ind)
    begin
      dec_o.legal = 1'b1;
      dec_o.src   = is_reg ? LOC_REG : LOC_IND;
      dec_o.dst   = LOC_ACC;
      unique case (hi)
        `HI_AND: dec_o.op = OPC_AND;
        `HI_OR:  dec_o.op = OPC_OR;
        `HI_XOR: dec_o.op = OPC_XOR;
        `HI_LDA: dec_o.op = OPC_MOVE;
        `HI_STR:
        begin
          dec_o.op  = OPC_MOVE;
          dec_o.src = LOC_ACC;
          dec_o.dst = is_reg ? LOC_REG : LOC_IND;
        end
        `HI_LDRD:
        begin
          dec_o.op     = OPC_MOVE;
          dec_o.src    = LOC_DIR;
          dec_o.dst    = is_reg ? LOC_REG : LOC_IND;
          dec_o.bytes  = 2'h2;
          dec_o.cycles = 2'h2;
        end
        `HI_LDRI:
        begin
          dec_o.op    = OPC_MOVE;
          dec_o.src   = LOC_IMM;
          dec_o.dst   = is_reg ? LOC_REG : LOC_IND;
          dec_o.bytes = 2'h2;
        end
        `HI_STD:
        begin
          dec_o.op     = OPC_MOVE;
          dec_o.dst    = LOC_DIR;
          dec_o.bytes  = 2'h2;
          dec_o.cycles = 2'h2;
        end
        `HI_XCH: dec_o.op = OPC_XCH;
        `HI_LOW_DIGIT_EXCHANGE_OP:
        begin
          dec_o.op    = OPC_LOW_DIGIT_EXCHANGE_OP;
          dec_o.legal = is_ind;
        end
        default: dec_o.legal = 1'b0;
      endcase
    end
    else if (lo[3:1] == `LO_XIND && (hi == `HI_XRD || hi == `HI_XWR))
    begin
      // eight-bit indirect external moves
      dec_o.legal   = 1'b1;
      dec_o.cycles  = 2'h2;
      dec_o.op      = (hi == `HI_XRD) ? OPC_XRD : OPC_XWR;
      dec_o.src     = (hi == `HI_XRD) ? LOC_IND : LOC_ACC;
      dec_o.dst     = (hi == `HI_XRD) ? LOC_ACC : LOC_IND;
    end
    else
    begin
      dec_o.legal = 1'b1;
      unique case (opcode_i)
        `OP_AND_A_DIR, `OP_OR_A_DIR, `OP_XOR_A_DIR, `OP_LD_A_DIR,
        `OP_XCH_DIR:
        begin
          dec_o.dst   = LOC_ACC;
          dec_o.src   = LOC_DIR;
          dec_o.bytes = 2'h2;
        end
        `OP_AND_A_IMM, `OP_OR_A_IMM, `OP_XOR_A_IMM, `OP_LD_A_IMM:
        begin
          dec_o.dst   = LOC_ACC;
          dec_o.src   = LOC_IMM;
          dec_o.bytes = 2'h2;
        end
        `OP_AND_DIR_A, `OP_OR_DIR_A, `OP_XOR_DIR_A, `OP_ST_DIR_A:
        begin
          dec_o.dst   = LOC_DIR;
          dec_o.src   = LOC_ACC;
          dec_o.bytes = 2'h2;
        end
        `OP_AND_DIR_IMM, `OP_OR_DIR_IMM, `OP_XOR_DIR_IMM, `OP_ST_DIR_IMM,
        `OP_CP_DIR_DIR:
        begin
          dec_o.dst    = LOC_DIR;
          dec_o.src    = (opcode_i == `OP_CP_DIR_DIR) ? LOC_DIR : LOC_IMM;
          dec_o.bytes  = `MAX_BYTES;
          dec_o.cycles = 2'h2;
        end
        `OP_LD_DATA_POINTER:
        begin
          dec_o.dst    = LOC_DATA_POINTER;
          dec_o.src    = LOC_IMM;
          dec_o.bytes  = `MAX_BYTES;
          dec_o.cycles = 2'h2;
        end
        `OP_CODE_DATA_POINTER, `OP_CODE_PC, `OP_XRD_DATA_POINTER, `OP_XWR_DATA_POINTER:
        begin
          dec_o.cycles = 2'h2;
          dec_o.dst    = (opcode_i == `OP_XWR_DATA_POINTER) ? LOC_DATA_POINTER : LOC_ACC;
          dec_o.src    = (opcode_i == `OP_XWR_DATA_POINTER) ? LOC_ACC : LOC_DATA_POINTER;
        end
        `OP_PUSH, `OP_POP:
        begin
          dec_o.src    = LOC_DIR;
          dec_o.bytes  = 2'h2;
          dec_o.cycles = 2'h2;
        end
        `OP_CLR_A, `OP_CPL_A, `OP_SWAP_A, `OP_RL_A, `OP_RLC_A, `OP_RR_A,
        `OP_RRC_A:
          dec_o.dst = LOC_ACC;
        default: dec_o.legal = 1'b0;
      endcase
      // class for the accumulator, direct, immediate and pointer forms
      unique case (opcode_i)
        `OP_AND_A_DIR, `OP_AND_A_IMM, `OP_AND_DIR_A, `OP_AND_DIR_IMM:
          dec_o.op = OPC_AND;
        `OP_OR_A_DIR, `OP_OR_A_IMM, `OP_OR_DIR_A, `OP_OR_DIR_IMM:
          dec_o.op = OPC_OR;
        `OP_XOR_A_DIR, `OP_XOR_A_IMM, `OP_XOR_DIR_A, `OP_XOR_DIR_IMM:
          dec_o.op = OPC_XOR;
        `OP_LD_A_DIR, `OP_LD_A_IMM, `OP_ST_DIR_A, `OP_ST_DIR_IMM,
        `OP_CP_DIR_DIR: dec_o.op = OPC_MOVE;
        `OP_XCH_DIR:   dec_o.op = OPC_XCH;
        `OP_LD_DATA_POINTER:   dec_o.op = OPC_LD_DATA_POINTER;
        `OP_CODE_DATA_POINTER: dec_o.op = OPC_CODE_DATA_POINTER;
        `OP_CODE_PC:   dec_o.op = OPC_CODE_PC;
        `OP_XRD_DATA_POINTER:  dec_o.op = OPC_XRD;
        `OP_XWR_DATA_POINTER:  dec_o.op = OPC_XWR;
        `OP_PUSH:      dec_o.op = OPC_PUSH;
        `OP_POP:       dec_o.op = OPC_POP;
        `OP_CLR_A:     dec_o.op = OPC_CLR;
        `OP_CPL_A:     dec_o.op = OPC_CPL;
        `OP_SWAP_A:    dec_o.op = OPC_SWAP;
        `OP_RL_A:      dec_o.op = OPC_RL;
        `OP_RLC_A:     dec_o.op = OPC_RLC;
        `OP_RR_A:      dec_o.op = OPC_RR;
        `OP_RRC_A:     dec_o.op = OPC_RRC;
        default:       dec_o.op = OPC_ILLEGAL;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: logic/mcycle_timer.sv
// Purpose: machine cycle enable from the core clock
// Assumes: one oscillator period per core clock
// Notes:   pulse is one clock wide, once per machine cycle
`timescale 1ns/10ps
`default_nettype none
`include "opdec_defines.svh"

module mcycle_timer #(
  parameter int OSC_PER_MC = `OSC_PER_MCYCLE
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  output logic      mc_tick_o
);

  // refused at elaboration: the divider counts in eight bits
  if (OSC_PER_MC < 2 || OSC_PER_MC > 255)
  begin : g_bad_period
    $error("mcycle_timer: period count out of range");
  end

  localparam logic [7:0] LAST = 8'(OSC_PER_MC - 1);

  logic [7:0] count;

  // ************************************************************
  // divider
  // ************************************************************
  // wraps every OSC_PER_MC clocks, twelve by default, so two machine cycles span 24 periods
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      count <= 8'h00;
    else if (count == LAST)
      count <= 8'h00;
    else
      count <= count + 8'h01;
  end

  assign mc_tick_o = (count == LAST);

endmodule
`default_nettype wire

// file: logic/opdec_top.sv
// Purpose: fetch sequencer and decoder for logic and transfer opcodes
// Assumes: program memory marks each offered byte with code_valid_i; wait states allowed
// Notes:   arithmetic, boolean and branch opcodes flag as not legal
`timescale 1ns/10ps
`default_nettype none
`include "opdec_defines.svh"

module opdec_top
  import opdec_pkg::*;
#(
  parameter int OSC_PER_MC = `OSC_PER_MCYCLE
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] code_byte_i,
  input  wire logic       code_valid_i,
  input  wire logic [1:0] bank_sel_i,
  input  wire logic       exec_ready_i,
  output logic            fetch_req_o,
  output logic            mc_tick_o,
  output logic            instr_valid_o,
  output instr_t          instr_o,
  output logic [7:0]      opcode_o,
  output logic [4:0]      ind_reg_addr_o,
  output logic            acc_self_load_o
);

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    S_OPCODE = 3'b000,
    S_OPER1  = 3'b001,
    S_OPER2  = 3'b011,
    S_EXEC   = 3'b010,
    S_HOLD   = 3'b110
  } seq_t;

  localparam logic [7:0] ACC_DIRECT = `ACC_DIR_ADDR;

  seq_t       state;
  seq_t       next_state;
  dec_t       dec_now;
  dec_t       dec_held;
  logic [7:0] opcode;
  logic [7:0] op1;
  logic [7:0] op2;
  logic [1:0] cyc_left;
  logic       take;
  logic       tick;

  assign take = code_valid_i && fetch_req_o;

  // ************************************************************
  // submodules
  // ************************************************************
  // table decodes the live byte in every state; its result is used only in the opcode slot
  opdec_table u_table (
    .opcode_i (code_byte_i),
    .dec_o    (dec_now)
  );

  mcycle_timer #(
    .OSC_PER_MC (OSC_PER_MC)
  ) u_timer (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .mc_tick_o (tick)
  );

  assign mc_tick_o = tick;

  // ************************************************************
  // fetch request
  // ************************************************************
  // bytes are asked for only while collecting an instruction
  always_comb
  begin
    fetch_req_o = (state == S_OPCODE) || (state == S_OPER1) ||
                  (state == S_OPER2);
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      S_OPCODE:
        if (take)
          next_state = (dec_now.bytes == 2'h1) ? S_EXEC : S_OPER1;
      S_OPER1:
        if (take)
          next_state = (dec_held.bytes == `MAX_BYTES) ? S_OPER2 : S_EXEC;
      S_OPER2:
        if (take)
          next_state = S_EXEC;
      S_EXEC:
        // wait out the machine cycles of the instruction
        if (tick && cyc_left == 2'h1)
          next_state = S_HOLD;
      S_HOLD:
        if (exec_ready_i)
          next_state = S_OPCODE;
      default:
        next_state = S_OPCODE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= S_OPCODE;
    else
      state <= next_state;
  end

  // ************************************************************
  // instruction capture
  // ************************************************************
  // decode is latched with the opcode so later bytes cannot alter it
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      opcode   <= 8'h00;
      dec_held <= '0;
    end
    else if (state == S_OPCODE && take)
    begin
      opcode   <= code_byte_i;
      dec_held <= dec_now;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      op1 <= 8'h00;
      op2 <= 8'h00;
    end
    else if (state == S_OPCODE && take)
    begin
      op1 <= 8'h00;
      op2 <= 8'h00;
    end
    else if (state == S_OPER1 && take)
      op1 <= code_byte_i;
    else if (state == S_OPER2 && take)
      op2 <= code_byte_i;
  end

  // ************************************************************
  // machine cycle count
  // ************************************************************
  // counts ticks after the last byte; one or two per table entry
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      cyc_left <= 2'h0;
    else if (state == S_OPCODE && take)
      cyc_left <= dec_now.cycles;
    else if (state == S_EXEC && tick && cyc_left != 2'h0)
      cyc_left <= cyc_left - 2'h1;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // handshake: valid stands until the executor accepts
  assign instr_valid_o = (state == S_HOLD);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      instr_o  <= '0;
      opcode_o <= 8'h00;
    end
    else if (next_state == S_HOLD && state == S_EXEC)
    begin
      instr_o.dec      <= dec_held;
      instr_o.operand1 <= op1;
      instr_o.operand2 <= op2;
      opcode_o         <= opcode;
    end
  end

  // indirect pointer lives at bank*8 + 0 or 1
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ind_reg_addr_o <= 5'h00;
    else if (next_state == S_HOLD && state == S_EXEC)
      ind_reg_addr_o <= {bank_sel_i, dec_held.reg_sel};
  end

  // flags the forbidden self load; it still goes out legal, so the core must guard it
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      acc_self_load_o <= 1'b0;
    else if (next_state == S_HOLD && state == S_EXEC)
      acc_self_load_o <= (opcode == `OP_LD_A_DIR) &&
                         (op1 == ACC_DIRECT);
  end

endmodule
`default_nettype wire

// file: testbench/opdec_top_asserts.sv
// Purpose: port level checks for the opcode decoder top
// Assumes: one clock domain, asynchronous active low reset
// Notes:   counters let the timing checks work for any tick period
`timescale 1ns/10ps
`default_nettype none

module opdec_top_asserts
  import opdec_pkg::*;
#(
  parameter int OSC_PER_MC = 12
) (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic [7:0] code_byte_i,
  input wire logic       code_valid_i,
  input wire logic [1:0] bank_sel_i,
  input wire logic       exec_ready_i,
  input wire logic       fetch_req_o,
  input wire logic       mc_tick_o,
  input wire logic       instr_valid_o,
  input wire instr_t     instr_o,
  input wire logic [7:0] opcode_o,
  input wire logic [4:0] ind_reg_addr_o,
  input wire logic       acc_self_load_o
);
  // ************************************************************
  // helper counters
  // ************************************************************
  logic       taken;
  logic [7:0] tick_gap;
  logic [3:0] ticks_seen;
  logic [2:0] bytes_seen;

  assign taken = code_valid_i && fetch_req_o;

  // clocks since the last machine cycle tick
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) tick_gap <= 8'h00;
    else tick_gap <= mc_tick_o ? 8'h00 : tick_gap + 8'h01;

  // ticks since the last byte; a tick on the byte edge is fetch time,
  // so execution counting starts with the next one
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) ticks_seen <= 4'h0;
    else if (taken) ticks_seen <= 4'h0;
    else if (mc_tick_o && ticks_seen != 4'hF) ticks_seen <= ticks_seen + 4'h1;

  // bytes taken for the instruction now being assembled
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) bytes_seen <= 3'h0;
    else if (instr_valid_o && exec_ready_i) bytes_seen <= 3'h0;
    else if (taken) bytes_seen <= bytes_seen + 3'h1;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // ************************************************************
  // properties
  // ************************************************************
  sequence s_accept;
    instr_valid_o && exec_ready_i;
  endsequence
  sequence s_wait;
    instr_valid_o && !exec_ready_i;
  endsequence

  a_tick_period: assert property (mc_tick_o == (int'(tick_gap) == OSC_PER_MC - 1))
    else $error("machine cycle tick out of period");
  a_exec_cycles: assert property ($rose(instr_valid_o) |-> ticks_seen == {2'h0, instr_o.dec.cycles})
    else $error("execution took wrong tick count");
  a_byte_count: assert property ($rose(instr_valid_o) |-> bytes_seen == {1'b0, instr_o.dec.bytes})
    else $error("instruction byte count wrong");
  a_hold_stable: assert property (s_wait |=> instr_valid_o && $stable(instr_o) && $stable(opcode_o))
    else $error("held instruction changed");
  a_no_fetch_hold: assert property (instr_valid_o |-> !fetch_req_o)
    else $error("fetch while instruction held");
  a_accept_next: assert property (s_accept |=> fetch_req_o && !instr_valid_o)
    else $error("no return to fetch after accept");
  a_self_flag: assert property (instr_valid_o |-> acc_self_load_o == (opcode_o == 8'hE5 && instr_o.operand1 == 8'hE0))
    else $error("self load flag wrong");
  a_ind_addr: assert property (instr_valid_o && instr_o.dec.legal && opcode_o[3:1] == 3'h3 |-> ind_reg_addr_o == {bank_sel_i, 2'h0, opcode_o[0]})
    else $error("indirect register address wrong");
  a_reg_select: assert property (instr_valid_o && instr_o.dec.legal && opcode_o[3] |-> instr_o.dec.reg_sel == opcode_o[2:0])
    else $error("working register select wrong");
endmodule

bind opdec_top opdec_top_asserts #(.OSC_PER_MC(OSC_PER_MC)) u_asserts (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .code_byte_i(code_byte_i),
  .code_valid_i(code_valid_i), .bank_sel_i(bank_sel_i),
  .exec_ready_i(exec_ready_i), .fetch_req_o(fetch_req_o),
  .mc_tick_o(mc_tick_o), .instr_valid_o(instr_valid_o),
  .instr_o(instr_o), .opcode_o(opcode_o),
  .ind_reg_addr_o(ind_reg_addr_o), .acc_self_load_o(acc_self_load_o)
);

`default_nettype wire

// file: testbench/code_mem_model.sv
// Purpose: program memory partner that offers opcode and operand bytes
// Assumes: the bench pushes bytes in program order
// Notes:   slow mode inserts random wait states between bytes
`timescale 1ns/10ps
`default_nettype none

module code_mem_model (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       fetch_req_i,
  input  wire logic       slow_i,
  output logic [7:0]      code_byte_o,
  output logic            code_valid_o
);
  logic [7:0] fifo [$];
  logic [7:0] last;
  logic       taken;

  // ************************************************************
  // byte delivery
  // ************************************************************
  task automatic push(input logic [7:0] b);
    fifo.push_back(b);
  endtask

  // request is combinational, so read it away from the edge
  always @(negedge clk_i)
    taken = code_valid_o && fetch_req_i;

  // an offered byte stands until taken; an idle bus shows the inverse
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      code_valid_o <= 1'b0;
      code_byte_o  <= 8'h00;
      last = 8'h00;
    end
    else if (!(code_valid_o && !taken))
    begin
      if (taken) last = fifo.pop_front();
      if (fifo.size() > 0 && !(slow_i && $urandom_range(1, 0) == 1))
      begin
        code_valid_o <= 1'b1;
        code_byte_o  <= fifo[0];
      end
      else
      begin
        code_valid_o <= 1'b0;
        code_byte_o  <= ~last;
      end
    end
  end
endmodule

`default_nettype wire

// file: testbench/logic_and_transfer_opcode_decoder_test.sv
// Purpose: self checking bench for the logic and transfer decoder
// Assumes: short machine cycle parameter to keep the run brief
// Notes:   every one of the 256 opcodes is fed through once, then E5, 53 and 90 again
`timescale 1ns/10ps
`default_nettype none

module logic_and_transfer_opcode_decoder_test;
  import opdec_pkg::*;
  localparam int OSC = 2;
  logic clk_i = 1'b0, reset_n_i = 1'b0, exec_ready_i = 1'b0, slow_i = 1'b0;
  logic [1:0] bank_sel_i = 2'h0;
  logic [7:0] code_byte_i, opcode_o;
  logic       code_valid_i, fetch_req_o, mc_tick_o, instr_valid_o;
  logic       acc_self_load_o;
  logic [4:0] ind_reg_addr_o;
  instr_t     instr_o;
  int         err_total = 0, samples_checked = 0;

  always #4 clk_i = ~clk_i;

  opdec_top #(.OSC_PER_MC(OSC)) u_opdec_top (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .code_byte_i(code_byte_i),
    .code_valid_i(code_valid_i), .bank_sel_i(bank_sel_i),
    .exec_ready_i(exec_ready_i), .fetch_req_o(fetch_req_o),
    .mc_tick_o(mc_tick_o), .instr_valid_o(instr_valid_o),
    .instr_o(instr_o), .opcode_o(opcode_o),
    .ind_reg_addr_o(ind_reg_addr_o), .acc_self_load_o(acc_self_load_o));
  code_mem_model u_code_mem_model (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .fetch_req_i(fetch_req_o),
    .slow_i(slow_i), .code_byte_o(code_byte_i), .code_valid_o(code_valid_i));

  // ************************************************************
  // reference table: class, length and cycles of each opcode
  // ************************************************************
  function automatic dec_t ref_dec(input logic [7:0] o);
    dec_t d;
    logic [3:0] l;
    logic [4:0] opv;
    l = o[3:0];
    d = '0;
    opv = '0;
    d.legal = 1'b1;
    d.bytes = 2'h1;
    d.cycles = 2'h1;
    d.op = OPC_MOVE;
    casez (o)
      8'h4?, 8'h5?, 8'h6?:
      begin
        d.op = o[7:4] == 4'h4 ? OPC_OR : o[7:4] == 4'h5 ? OPC_AND : OPC_XOR;
        d.legal = l > 4'h1;
        d.bytes = l == 4'h3 ? 2'h3 : (l inside {[4'h2:4'h5]}) ? 2'h2 : 2'h1;
        d.cycles = l == 4'h3 ? 2'h2 : 2'h1;
      end
      8'hE4: d.op = OPC_CLR;
      8'hF4: d.op = OPC_CPL;
      8'hC4: d.op = OPC_SWAP;
      8'h23: d.op = OPC_RL;
      8'h33: d.op = OPC_RLC;
      8'h03: d.op = OPC_RR;
      8'h13: d.op = OPC_RRC;
      8'hE0, 8'hE2, 8'hE3: {opv, d.cycles} = {OPC_XRD, 2'h2};
      8'hF0, 8'hF2, 8'hF3: {opv, d.cycles} = {OPC_XWR, 2'h2};
      8'h90: {opv, d.bytes, d.cycles} = {OPC_LD_DATA_POINTER, 2'h3, 2'h2};
      8'h93: {opv, d.cycles} = {OPC_CODE_DATA_POINTER, 2'h2};
      8'h83: {opv, d.cycles} = {OPC_CODE_PC, 2'h2};
      8'hC0: {opv, d.bytes, d.cycles} = {OPC_PUSH, 2'h2, 2'h2};
      8'hD0: {opv, d.bytes, d.cycles} = {OPC_POP, 2'h2, 2'h2};
      8'hD6, 8'hD7: d.op = OPC_LOW_DIGIT_EXCHANGE_OP;
      8'hC5: {opv, d.bytes} = {OPC_XCH, 2'h2};
      8'hC6, 8'hC7, 8'b1100_1???: d.op = OPC_XCH;
      8'h74, 8'h76, 8'h77, 8'hF5, 8'hE5, 8'b0111_1???: d.bytes = 2'h2;
      8'h75, 8'h85: {d.bytes, d.cycles} = {2'h3, 2'h2};
      8'h86, 8'h87, 8'hA6, 8'hA7, 8'b1000_1???, 8'b1010_1???:
        {d.bytes, d.cycles} = {2'h2, 2'h2};
      8'hE6, 8'hE7, 8'hF6, 8'hF7, 8'b1110_1???, 8'b1111_1???: ;
      default: d.legal = 1'b0;
    endcase
    // class codes packed with a length or cycle count come back as the enum
    if (opv != 5'h00)
      d.op = op_class_t'(opv);
    return d;
  endfunction

  // ************************************************************
  // compare, verdict and instruction tasks
  // ************************************************************
  task automatic compare(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic run_instr(input logic [7:0] opc, input logic [7:0] a,
                           input logic [7:0] b);
    dec_t e;
    logic [1:0] bank;
    logic rs;
    int n;
    e = ref_dec(opc);
    bank = 2'($urandom_range(3, 0));
    rs = e.legal && (opc[3] || opc[3:1] == 3'h3 ||
         (opc[7:5] == 3'h7 && opc[3:1] == 3'h1));
    @(posedge clk_i);
    bank_sel_i <= bank;
    slow_i <= 1'($urandom_range(1, 0));
    u_code_mem_model.push(opc);
    if (e.bytes > 2'h1) u_code_mem_model.push(a);
    if (e.bytes > 2'h2) u_code_mem_model.push(b);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (instr_valid_o !== 1'b1 && n < 300);
    if (n >= 300)
    begin
      err_total++;
      $display("Error at %0t: no instruction for %h", $time, opc);
      end_of_test();
    end
    else
    begin
      compare(opcode_o, opc, "opcode");
      compare({7'h0, instr_o.dec.legal}, {7'h0, e.legal}, "legal");
      compare({6'h0, instr_o.dec.bytes}, {6'h0, e.bytes}, "bytes");
      compare({6'h0, instr_o.dec.cycles}, {6'h0, e.cycles}, "cycles");
      if (e.legal)
        compare({3'h0, instr_o.dec.op}, {3'h0, e.op}, "class");
      if (e.bytes > 2'h1) compare(instr_o.operand1, a, "operand1");
      if (e.bytes > 2'h2) compare(instr_o.operand2, b, "operand2");
      compare({7'h0, acc_self_load_o}, {7'h0, opc == 8'hE5 && a == 8'hE0}, "self");
      if (rs)
        compare({3'h0, ind_reg_addr_o},
                {3'h0, bank, opc[3] ? opc[2:0] : {2'h0, opc[0]}}, "reg");
      repeat ($urandom_range(2, 0)) @(posedge clk_i);
      @(posedge clk_i);
      exec_ready_i <= 1'b1;
      @(posedge clk_i);
      exec_ready_i <= 1'b0;
    end
  endtask

  // ************************************************************
  // main sequence: full opcode sweep, self load, mid run reset
  // ************************************************************
  initial
  begin
    void'($urandom(32'hFDE2));
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 256; i++)
      run_instr(8'(i), 8'($urandom), 8'($urandom));
    run_instr(8'hE5, 8'hE0, 8'h00);
    run_instr(8'h53, 8'h00, 8'hFF);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    run_instr(8'h90, 8'h12, 8'h34);
    end_of_test();
  end
endmodule

`default_nettype wire
